// ==== logic/iod_pkg.sv ====
// Purpose: Shared constants and types for the instruction operand decoder
// Assumes: 16-bit instruction words, 8-bit datapath, 32-bit classic Wishbone
// Notes:   Positions, reset values and timing counts named once
// Contract
// RULE_01: Access bit 0 selects access RAM, ignoring bank register; 1 uses bank register.
// RULE_02: Bit instructions pick one bit 0..7 of the addressed byte by 3-bit index.
// RULE_03: Destination bit 0 writes accumulator; 1 writes back to the addressed register.
// RULE_04: Register field is an 8-bit address or a 2-bit pointer designator.
// RULE_05: Two-word move carries full 12-bit source and target, no bank involvement.
// RULE_06: Literal field extracted as 8, 12 or 20 bits per instruction.
// RULE_07: Table access applies none, post-increment, post-decrement or pre-increment to pointer.
// RULE_08: Table pointer is 21 bits into program memory; data passes 8-bit table latch.
// RULE_09: Fast bit 1 saves or restores shadow copies; 0 leaves shadows untouched.
// RULE_10: Relative branches use two's complement offset; call/goto/return use direct address.
// RULE_11: Indexed addressing adds 7-bit source or target offset to the selected pointer.
// RULE_12: Five status flags kept: carry, half carry, zero, overflow, negative.
// RULE_13: Multiply result held as separate product high and low bytes.
// RULE_14: Don't-care bits encoded as zero by tools; device ignores their value.
// RULE_15: Second word has top four bits ones; executed alone it is a no-operation.
// RULE_16: Instruction cycle is four clocks; skip or jump adds one no-operation cycle.
// RULE_17: Operand fields extracted combinationally, presented in the decode cycle.
package iod_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADR_BANK   = 8'h00;
   localparam logic [7:0] ADR_ACC    = 8'h04;
   localparam logic [7:0] ADR_STATUS = 8'h08;
   localparam logic [7:0] ADR_PROD   = 8'h0c;
   localparam logic [7:0] ADR_TPTR   = 8'h10;
   localparam logic [7:0] ADR_TLAT   = 8'h14;
   localparam logic [7:0] ADR_DECODE = 8'h18;
   localparam logic [7:0] ADR_IR     = 8'h1c;
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [4:0] RST_FLAGS  = 5'h00;
   localparam logic [20:0] RST_TPTR  = 21'h000000;
   localparam logic [15:0] NOP_WORD  = 16'h0000;
   // ----------------------------------------------------------------
   // Field positions and widths
   // ----------------------------------------------------------------
   localparam int TPTR_W     = 21;
   localparam int ADDR_W     = 12;
   localparam int POS_ACCESS = 8;
   localparam int POS_DEST   = 9;
   localparam int POS_BIT    = 9;
   localparam int POS_PTR    = 4;
   localparam int POS_TBLWR  = 2;
   localparam int POS_FASTC  = 8;
   localparam int POS_FASTR  = 0;
   localparam logic [3:0] SECOND_TAG = 4'hf;
   localparam logic [3:0] BANK_LOW   = 4'h0;
   localparam logic [3:0] BANK_HIGH  = 4'hf;
   // Status flag bit positions
   localparam int FLG_C  = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z  = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N  = 4;
   // ----------------------------------------------------------------
   // Timing: one instruction cycle is four clocks
   // ----------------------------------------------------------------
   localparam int CLK_PER_CYCLE = 4;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      FMT_NONE = 4'h0, FMT_BYTE  = 4'h1, FMT_BIT   = 4'h2, FMT_LIT8  = 4'h3,
      FMT_LPTR = 4'h4, FMT_MOVE  = 4'h5, FMT_TABLE = 4'h6, FMT_CALL  = 4'h7,
      FMT_GOTO = 4'h8, FMT_REL8  = 4'h9, FMT_REL11 = 4'ha, FMT_RET   = 4'hb,
      FMT_IDX  = 4'hc
   } iod_fmt_t;
   typedef enum logic [1:0] {
      TM_NONE = 2'h0, TM_POST_INC = 2'h1, TM_POST_DEC = 2'h2, TM_PRE_INC = 2'h3
   } iod_tmode_t;
   // Gray-coded clock phase within an instruction cycle
   typedef enum logic [1:0] {
      PH_1 = 2'b00, PH_2 = 2'b01, PH_3 = 2'b11, PH_4 = 2'b10
   } iod_phase_t;
endpackage : iod_pkg

// ==== logic/iod_fld_if.sv ====
// Purpose: Carries an instruction pair and its extracted operand fields
// Assumes: Combinational use inside the decoder only
// Notes:   ext side drives fields, core side drives words
`timescale 1ns/1ns
`default_nettype none
interface iod_fld_if;
   import iod_pkg::*;
   logic [15:0] word1;
   logic [15:0] word2;
   iod_fmt_t    fmt;
   logic        access;
   logic        dest;
   logic [2:0]  bit_sel;
   logic [7:0]  file_addr;
   logic [1:0]  ptr_sel;
   logic [7:0]  lit8;
   logic [11:0] lit12;
   logic [19:0] lit20;
   logic [11:0] src_addr;
   logic [11:0] dst_addr;
   logic        fast;
   iod_tmode_t  tmode;
   logic        tbl_wr;
   logic [20:0] br_off;
   logic        br_abs;
   logic [6:0]  src_off;
   logic [6:0]  dst_off;
   modport ext  (input word1, word2, fmt,
                 output access, dest, bit_sel, file_addr, ptr_sel, lit8, lit12, lit20,
                 src_addr, dst_addr, fast, tmode, tbl_wr, br_off, br_abs, src_off, dst_off);
   modport core (output word1, word2, fmt,
                 input access, dest, bit_sel, file_addr, ptr_sel, lit8, lit12, lit20,
                 src_addr, dst_addr, fast, tmode, tbl_wr, br_off, br_abs, src_off, dst_off);
endinterface : iod_fld_if
`default_nettype wire

// ==== logic/iod_field_ext.sv ====
// Purpose: Pure combinational operand field extraction
// Assumes: Format chosen by the opcode decoder outside
// Notes:   Only defined bit positions are read
`timescale 1ns/1ns
`default_nettype none
module iod_field_ext (
   // Instruction words and fields
   iod_fld_if.ext f
);
   import iod_pkg::*;
   always_comb begin
      f.access    = f.word1[POS_ACCESS];                  // [RULE_01]
      f.dest      = f.word1[POS_DEST];                    // [RULE_03]
      f.bit_sel   = f.word1[POS_BIT +: 3];                // [RULE_02]
      f.file_addr = f.word1[7:0];                         // [RULE_04]
      f.ptr_sel   = f.word1[POS_PTR +: 2];                // [RULE_04]
      f.lit8      = f.word1[7:0];                         // [RULE_06]
      f.lit12     = {f.word1[3:0], f.word2[7:0]};         // [RULE_06]
      f.lit20     = {f.word2[11:0], f.word1[7:0]};        // [RULE_06]
      f.src_addr  = f.word1[11:0];                        // [RULE_05]
      f.dst_addr  = f.word2[11:0];                        // [RULE_05]
      f.src_off   = f.word1[6:0];                         // [RULE_11]
      f.dst_off   = f.word2[6:0];                         // [RULE_11]
      f.tmode     = iod_tmode_t'(f.word1[1:0]);           // [RULE_07]
      f.tbl_wr    = f.word1[POS_TBLWR];
      // Fast bit sits low on returns, above the address on calls
      f.fast      = (f.fmt == FMT_CALL) ? f.word1[POS_FASTC] : f.word1[POS_FASTR];
      // Unused bits never reach the branch offset [RULE_14]
      case (f.fmt)
         FMT_REL8: begin
            f.br_off = {{13{f.word1[7]}}, f.word1[7:0]};   // [RULE_10]
            f.br_abs = 1'b0;
         end
         FMT_REL11: begin
            f.br_off = {{10{f.word1[10]}}, f.word1[10:0]}; // [RULE_10]
            f.br_abs = 1'b0;
         end
         FMT_CALL, FMT_GOTO: begin
            f.br_off = {1'b0, f.word2[11:0], f.word1[7:0]}; // [RULE_10]
            f.br_abs = 1'b1;
         end
         FMT_RET: begin
            f.br_off = 21'h000000;
            f.br_abs = 1'b1;
         end
         default: begin
            f.br_off = 21'h000000;
            f.br_abs = 1'b0;
         end
      endcase
   end
endmodule : iod_field_ext
`default_nettype wire

// ==== logic/iod_top.sv ====
// Purpose: Operand decode, cycle pacing and core working registers
// Assumes: Opcode class given by fmt_i; program memory read data is combinational
// Notes:   Registers on classic Wishbone, single clock, clock enable freezes all
`timescale 1ns/1ns
`default_nettype none
module iod_top #(
   parameter logic [7:0] ACCESS_SPLIT = 8'h80
) (
   // Clock, reset, enable
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   input  wire logic              ce_i,
   // Wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [31:0]       wb_dat_i,
   input  wire logic [3:0]        wb_sel_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // Fetch path
   input  wire logic [15:0]       instr_i,
   input  wire logic              instr_valid_i,
   input  wire iod_pkg::iod_fmt_t fmt_i,
   output logic                   cycle_start_o,
   output logic                   exec_o,
   // Control flow from the datapath
   input  wire logic              skip_i,
   input  wire logic              pc_change_i,
   // Decoded operands
   output iod_pkg::iod_fmt_t      fmt_o,
   output logic      [11:0]       data_addr_o,
   output logic      [11:0]       data_addr2_o,
   output logic      [7:0]        bit_mask_o,
   output logic      [19:0]       literal_o,
   output logic      [20:0]       branch_off_o,
   output logic                   branch_abs_o,
   // Indirect pointers
   input  wire logic [11:0]       ptr_val_i,
   output logic      [1:0]        ptr_sel_o,
   // Results and arithmetic status
   input  wire logic              result_we_i,
   input  wire logic [7:0]        result_i,
   output logic                   reg_wr_o,
   output logic      [7:0]        reg_wdata_o,
   input  wire logic              flags_we_i,
   input  wire logic [4:0]        flags_i,
   input  wire logic              prod_we_i,
   input  wire logic [15:0]       prod_i,
   output logic      [4:0]        flags_o,
   output logic      [7:0]        acc_o,
   // Program memory table port
   output logic      [20:0]       tbl_addr_o,
   output logic                   tbl_rd_o,
   output logic                   tbl_wr_o,
   output logic      [7:0]        tbl_wdata_o,
   input  wire logic [7:0]        tbl_rdata_i
);
   import iod_pkg::*;

   iod_fld_if fld ();

   iod_phase_t  phase_r, phase_nxt;
   logic [15:0] ir_r, ir2_r;
   iod_fmt_t    fmt_r;
   logic        want2_r, flush_r;
   logic [7:0]  bank_select_reg_r, working_accumulator_r;
   logic [4:0]  flags_r;
   logic [7:0]  product_high_byte_r, product_low_byte_r;
   logic [20:0] table_pointer_r;
   logic [7:0]  table_latch_r;
   logic [7:0]  sh_acc_r, sh_bank_r;
   logic [4:0]  sh_flags_r;
   logic        ack_r;
   logic [31:0] rdat_r;
   logic        exec, bus_wr, tbl_go, fast_call, fast_ret;
   logic [31:0] bus_old, bus_new;
   logic [20:0] tptr_inc, tptr_dec;

   // ----------------------------------------------------------------
   // Field extraction
   // ----------------------------------------------------------------
   assign fld.word1 = ir_r;
   assign fld.word2 = ir2_r;
   assign fld.fmt   = fmt_r;

   iod_field_ext u_ext (
      .f (fld.ext)
   );

   // ----------------------------------------------------------------
   // Instruction cycle phases
   // ----------------------------------------------------------------
   always_comb begin
      case (phase_r)
         PH_1:    phase_nxt = PH_2;
         PH_2:    phase_nxt = PH_3;
         PH_3:    phase_nxt = PH_4;
         PH_4:    phase_nxt = PH_1;
         default: phase_nxt = PH_1;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase_r <= PH_1;
      end else if (ce_i) begin
         phase_r <= phase_nxt;                            // [RULE_16]
      end
   end

   // Execute at the last phase unless still waiting for a second word
   assign exec          = ce_i && (phase_r == PH_4) && !want2_r;
   assign exec_o        = exec;
   assign cycle_start_o = ce_i && (phase_r == PH_1);

   // ----------------------------------------------------------------
   // Instruction register and double-word tracking
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ir_r    <= NOP_WORD;
         ir2_r   <= NOP_WORD;
         fmt_r   <= FMT_NONE;
         want2_r <= 1'b0;
         flush_r <= 1'b0;
      end else if (ce_i && phase_r == PH_4) begin
         if (!want2_r) begin
            // Skip or jump turns the cycle after the next one into a dead one
            flush_r <= skip_i || pc_change_i;             // [RULE_16]
         end else begin
            flush_r <= 1'b0;
         end
         if (want2_r) begin
            ir2_r   <= instr_i;                           // [RULE_05]
            want2_r <= 1'b0;
         end else if (flush_r || !instr_valid_i
                      || instr_i[15:12] == SECOND_TAG) begin
            // Lone second word or flushed slot acts as no-operation
            ir_r  <= NOP_WORD;                            // [RULE_15]
            ir2_r <= NOP_WORD;
            fmt_r <= FMT_NONE;
         end else begin
            ir_r    <= instr_i;
            ir2_r   <= NOP_WORD;
            fmt_r   <= fmt_i;
            want2_r <= (fmt_i == FMT_MOVE) || (fmt_i == FMT_CALL) || (fmt_i == FMT_GOTO)
                       || (fmt_i == FMT_IDX) || (fmt_i == FMT_LPTR);
         end
      end
   end

   // ----------------------------------------------------------------
   // Operand presentation, same cycle as decode
   // ----------------------------------------------------------------
   always_comb begin
      fmt_o        = fmt_r;                               // [RULE_17]
      ptr_sel_o    = fld.ptr_sel;                         // [RULE_04]
      branch_off_o = fld.br_off;                          // [RULE_10]
      branch_abs_o = fld.br_abs;
      bit_mask_o   = 8'h01 << fld.bit_sel;                // [RULE_02]
      data_addr2_o = 12'h000;
      literal_o    = {12'h000, fld.lit8};                 // [RULE_06]
      if (fld.access) begin
         data_addr_o = {bank_select_reg_r[3:0], fld.file_addr}; // [RULE_01]
      end else if (fld.file_addr < ACCESS_SPLIT) begin
         data_addr_o = {BANK_LOW, fld.file_addr};         // [RULE_01]
      end else begin
         data_addr_o = {BANK_HIGH, fld.file_addr};        // [RULE_01]
      end
      case (fmt_r)
         FMT_MOVE: begin
            data_addr_o  = fld.src_addr;                  // [RULE_05]
            data_addr2_o = fld.dst_addr;                  // [RULE_05]
         end
         FMT_IDX: begin
            data_addr_o  = ptr_val_i + {5'h00, fld.src_off}; // [RULE_11]
            data_addr2_o = ptr_val_i + {5'h00, fld.dst_off}; // [RULE_11]
         end
         FMT_LPTR: literal_o = {8'h00, fld.lit12};        // [RULE_06]
         FMT_CALL, FMT_GOTO: literal_o = fld.lit20;       // [RULE_06]
         default: ;
      endcase
   end

   // ----------------------------------------------------------------
   // Result routing
   // ----------------------------------------------------------------
   assign reg_wr_o    = result_we_i && fld.dest;          // [RULE_03]
   assign reg_wdata_o = result_i;
   assign acc_o       = working_accumulator_r;
   assign flags_o     = flags_r;

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------
   assign bus_wr   = ce_i && wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction : lane_merge

   assign bus_new = lane_merge(bus_old, wb_dat_i, wb_sel_i);

   always_comb begin
      case (wb_adr_i)
         ADR_BANK:   bus_old = {24'h000000, bank_select_reg_r};
         ADR_ACC:    bus_old = {24'h000000, working_accumulator_r};
         ADR_STATUS: bus_old = {27'h0000000, flags_r};
         ADR_PROD:   bus_old = {16'h0000, product_high_byte_r, product_low_byte_r};
         ADR_TPTR:   bus_old = {11'h000, table_pointer_r};
         ADR_TLAT:   bus_old = {24'h000000, table_latch_r};
         ADR_DECODE: bus_old = {12'h000, fmt_r, 4'h0, data_addr_o};
         ADR_IR:     bus_old = {ir_r, ir2_r};
         default:    bus_old = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h00000000;
      end else if (ce_i) begin
         ack_r  <= wb_cyc_i && wb_stb_i && !ack_r;
         rdat_r <= bus_old;
      end
   end

   // ----------------------------------------------------------------
   // Bank select and accumulator, with fast shadows
   // ----------------------------------------------------------------
   assign fast_call = exec && fmt_r == FMT_CALL && fld.fast;
   assign fast_ret  = exec && fmt_r == FMT_RET && fld.fast;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sh_acc_r   <= RST_BYTE;
         sh_bank_r  <= RST_BYTE;
         sh_flags_r <= RST_FLAGS;
      end else if (fast_call) begin
         sh_acc_r   <= working_accumulator_r;             // [RULE_09]
         sh_bank_r  <= bank_select_reg_r;                 // [RULE_09]
         sh_flags_r <= flags_r;                           // [RULE_09]
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         working_accumulator_r <= RST_BYTE;
         bank_select_reg_r     <= RST_BYTE;
      end else if (ce_i) begin
         if (fast_ret) begin
            working_accumulator_r <= sh_acc_r;            // [RULE_09]
            bank_select_reg_r     <= sh_bank_r;
         end else begin
            if (result_we_i && !fld.dest) begin
               working_accumulator_r <= result_i;         // [RULE_03]
            end else if (bus_wr && wb_adr_i == ADR_ACC) begin
               working_accumulator_r <= bus_new[7:0];
            end
            if (bus_wr && wb_adr_i == ADR_BANK) begin
               bank_select_reg_r <= bus_new[7:0];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Status flags and product bytes
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flags_r <= RST_FLAGS;
      end else if (ce_i) begin
         if (fast_ret) begin
            flags_r <= sh_flags_r;
         end else if (flags_we_i) begin
            flags_r <= flags_i;                           // [RULE_12]
         end else if (bus_wr && wb_adr_i == ADR_STATUS) begin
            flags_r <= bus_new[4:0];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         product_high_byte_r <= RST_BYTE;
         product_low_byte_r  <= RST_BYTE;
      end else if (ce_i && prod_we_i) begin
         product_high_byte_r <= prod_i[15:8];             // [RULE_13]
         product_low_byte_r  <= prod_i[7:0];              // [RULE_13]
      end
   end

   // ----------------------------------------------------------------
   // Table pointer and latch
   // ----------------------------------------------------------------
   assign tbl_go      = exec && fmt_r == FMT_TABLE;
   assign tptr_inc    = table_pointer_r + 21'h000001;
   assign tptr_dec    = table_pointer_r - 21'h000001;
   assign tbl_addr_o  = (fld.tmode == TM_PRE_INC) ? tptr_inc : table_pointer_r; // [RULE_07]
   assign tbl_rd_o    = tbl_go && !fld.tbl_wr;
   assign tbl_wr_o    = tbl_go && fld.tbl_wr;
   assign tbl_wdata_o = table_latch_r;                    // [RULE_08]

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         table_pointer_r <= RST_TPTR;
      end else if (ce_i) begin
         if (tbl_go) begin
            case (fld.tmode)
               TM_POST_INC, TM_PRE_INC: table_pointer_r <= tptr_inc; // [RULE_07]
               TM_POST_DEC: table_pointer_r <= tptr_dec;  // [RULE_07]
               default:     table_pointer_r <= table_pointer_r;
            endcase
         end else if (bus_wr && wb_adr_i == ADR_TPTR) begin
            table_pointer_r <= bus_new[TPTR_W-1:0];      // [RULE_08]
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         table_latch_r <= RST_BYTE;
      end else if (ce_i) begin
         if (tbl_rd_o) begin
            table_latch_r <= tbl_rdata_i;                 // [RULE_08]
         end else if (bus_wr && wb_adr_i == ADR_TLAT) begin
            table_latch_r <= bus_new[7:0];
         end
      end
   end

endmodule : iod_top
`default_nettype wire

// ==== tb/iod_top_monitor.sv ====
// Purpose: Port checks on the operand decoder
// Assumes: ce_i held high
// Notes:   Bound from the bench top
`timescale 1ns/1ns
`default_nettype none
module iod_top_monitor (
   // Clock, reset
   input wire logic        clk_i,
   input wire logic        rstn_i,
   // Watched ports
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        cycle_start_o,
   input wire logic        exec_o,
   input wire logic [7:0]  bit_mask_o,
   input wire logic [19:0] literal_o,
   input wire logic [11:0] data_addr_o,
   input wire logic        result_we_i,
   input wire logic [7:0]  result_i,
   input wire logic        reg_wr_o,
   input wire logic [7:0]  reg_wdata_o,
   input wire logic        tbl_rd_o,
   input wire logic        tbl_wr_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_quiet3; !cycle_start_o [*3]; endsequence
   sequence s_held3; ($stable(data_addr_o) && $stable(literal_o)) [*3]; endsequence
   property p_pace; cycle_start_o |=> s_quiet3 ##1 cycle_start_o; endproperty
   a_pace: assert property (p_pace) else $error("cycle pacing wrong");
   property p_exec; exec_o |=> cycle_start_o; endproperty
   a_exec: assert property (p_exec) else $error("exec not in last phase");
   property p_held; cycle_start_o |=> s_held3; endproperty
   a_held: assert property (p_held) else $error("operands moved mid cycle");
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack1: assert property (p_ack1) else $error("ack too long");
   property p_dest; reg_wr_o |-> result_we_i && reg_wdata_o == result_i; endproperty
   a_dest: assert property (p_dest) else $error("write back wrong");
   property p_mask; $onehot(bit_mask_o); endproperty
   a_mask: assert property (p_mask) else $error("bit mask not one hot");
   property p_tbl; tbl_rd_o || tbl_wr_o |-> exec_o && !(tbl_rd_o && tbl_wr_o); endproperty
   a_tbl: assert property (p_tbl) else $error("table strobe wrong");
endmodule : iod_top_monitor
`default_nettype wire

// ==== tb/iod_top_tb.sv ====
// Purpose: Directed bench for the operand decoder
// Assumes: Default access split 80
// Notes:   Bus and fetch driven at rising edges
`timescale 1ns/1ns
`default_nettype none
module iod_top_tb;
   import iod_pkg::*;
   logic clk_i = 0, rstn_i = 0, ce_i = 1, skip_i = 0, pc_change_i = 0, instr_valid_i = 0;
   logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, cycle_start_o, exec_o, branch_abs_o;
   logic [7:0] wb_adr_i = 0, result_i = 0, tbl_rdata_i = 0, bit_mask_o, reg_wdata_o, acc_o;
   logic [7:0] tbl_wdata_o;
   logic [31:0] wb_dat_i = 0, wb_dat_o;
   logic [3:0] wb_sel_i = 0;
   logic [15:0] instr_i = 0, prod_i = 0;
   logic [11:0] ptr_val_i = 0, data_addr_o, data_addr2_o;
   logic [4:0] flags_i = 0, flags_o;
   logic [19:0] literal_o;
   logic [20:0] branch_off_o, tbl_addr_o;
   logic [1:0] ptr_sel_o;
   logic result_we_i = 0, flags_we_i = 0, prod_we_i = 0, reg_wr_o, tbl_rd_o, tbl_wr_o;
   iod_fmt_t fmt_i = FMT_NONE, fmt_o;
   int checks = 0, miscompares = 0, cycles = 0;
   iod_top uut (.*);
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hf};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_sel_i} <= 6'h0;
   endtask : wb
   task automatic dec(input logic [15:0] w1, input logic [15:0] w2, input iod_fmt_t f,
                      input bit two);
      do @(negedge clk_i); while (cycle_start_o !== 1'b1);
      @(posedge clk_i);
      instr_i <= w1;
      fmt_i <= f;
      instr_valid_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      if (two) begin
         instr_i <= w2;
         repeat (4) @(posedge clk_i);
      end
      instr_valid_i <= 1'b0;
      @(negedge clk_i);
   endtask : dec
   task automatic t_access();
      logic [31:0] rd;
      logic [15:0] w [3] = '{16'h2634, 16'h2590, 16'h26c0};
      logic [11:0] e [3] = '{12'h034, 12'h590, 12'hfc0};
      wb(1'b1, ADR_BANK, 32'h5, rd);
      wb(1'b0, ADR_BANK, 32'h0, rd);
      chk(rd, 32'h5);
      result_we_i <= 1'b1;
      result_i <= 8'h3c;
      for (int i = 0; i < 3; i++) begin
         dec(w[i], 16'h0, FMT_BYTE, 0);
         chk(data_addr_o, e[i]);
         chk(reg_wr_o, w[i][9]);
      end
      chk(acc_o, 32'h3c);
      @(posedge clk_i);
      result_we_i <= 1'b0;
   endtask : t_access
   task automatic t_bit_move();
      logic [31:0] rd;
      for (int b = 0; b < 8; b++) begin
         dec({4'h8, b[2:0], 9'h010}, 16'h0, FMT_BIT, 0);
         chk(bit_mask_o, 32'h1 << b);
      end
      dec(16'hc123, 16'hfabc, FMT_MOVE, 1);
      chk({data_addr_o, data_addr2_o}, 24'h123abc);
      dec(16'hed12, 16'hf345, FMT_CALL, 1);
      chk(literal_o, 32'h34512);
      chk(branch_off_o, 32'h34512);
      dec(16'h0013, 16'h0, FMT_RET, 0);
      wb(1'b1, ADR_ACC, 32'h77, rd);
      repeat (2) @(negedge clk_i);
      chk(acc_o, 32'h3c);
      dec(16'he0f0, 16'h0, FMT_REL8, 0);
      chk(branch_off_o, 32'h1ffff0);
      dec(16'hf0f0, 16'h0, FMT_BYTE, 0);
      chk(fmt_o, FMT_NONE);
      @(posedge clk_i);
      skip_i <= 1'b1;
      dec(16'h2634, 16'h0, FMT_BYTE, 0);
      dec(16'h2590, 16'h0, FMT_BYTE, 0);
      chk(fmt_o, FMT_NONE);
      @(posedge clk_i);
      skip_i <= 1'b0;
   endtask : t_bit_move
   task automatic t_table();
      logic [31:0] rd;
      for (int m = 0; m < 4; m++) begin
         wb(1'b1, ADR_TPTR, 32'h1fffff, rd);
         dec({14'h2, m[1:0]}, 16'h0, FMT_TABLE, 0);
         chk(tbl_addr_o, (m == 3) ? 21'h0 : 21'h1fffff);
         repeat (4) @(posedge clk_i);
         wb(1'b0, ADR_TPTR, 32'h0, rd);
         chk(rd, (m == 0) ? 32'h1fffff : (m == 2) ? 32'h1ffffe : 32'h0);
      end
   endtask : t_table
   task automatic t_alu();
      logic [31:0] rd;
      @(posedge clk_i);
      {flags_we_i, flags_i, prod_we_i, prod_i} <= {1'b1, 5'h15, 1'b1, 16'ha55a};
      @(posedge clk_i);
      {flags_we_i, prod_we_i} <= 2'b00;
      wb(1'b0, ADR_STATUS, 32'h0, rd);
      chk(rd, 32'h15);
      wb(1'b1, ADR_PROD, 32'hffff, rd);
      wb(1'b0, ADR_PROD, 32'h0, rd);
      chk(rd, 32'ha55a);
      wb(1'b0, 8'h40, 32'h0, rd);
      chk(rd, 32'h0);
   endtask : t_alu
   initial begin
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_access();
      t_bit_move();
      t_table();
      t_alu();
      wrap_up();
   end
endmodule : iod_top_tb
bind iod_top iod_top_monitor u_mon (.*);
`default_nettype wire
